/* src/vsreg_pkg.sv */
package vsreg_pkg;

	// ------------------------------------------------------------
	// Register map (byte addresses of the low byte)
	// ------------------------------------------------------------
	localparam logic [6:0] DIAG_STATUS_ADDR   = 7'h3C;
	localparam logic [6:0] GLOBAL_CMD_ADDR    = 7'h3E;
	localparam logic [6:0] X_ALARM_STAT_ADDR  = 7'h40;
	localparam logic [15:0] DIAG_STATUS_RESET = 16'h0000;
	localparam logic [15:0] GLOBAL_CMD_RESET  = 16'h0000;
	localparam logic [15:0] X_ALARM_RESET     = 16'h0000;

	// ------------------------------------------------------------
	// Diagnostic status bit positions
	// ------------------------------------------------------------
	localparam int DS_SYS_ALARM   = 14;
	localparam int DS_SPEC2_LSB   = 11;
	localparam int DS_SPEC1_LSB   = 8;
	localparam int DS_DATA_READY  = 7;
	localparam int DS_CHECKSUM    = 6;
	localparam int DS_SELF_TEST   = 5;
	localparam int DS_ESCAPE      = 4;
	localparam int DS_COMM_FAIL   = 3;
	localparam int DS_FLASH_UPD   = 2;
	localparam int DS_SUPPLY_HIGH = 1;
	localparam int DS_SUPPLY_LOW  = 0;
	// Event flags held until the clear command; the rest follow conditions
	localparam logic [15:0] DS_EVENT_MASK = 16'h007C;

	// ------------------------------------------------------------
	// Global command bit positions
	// ------------------------------------------------------------
	localparam int GC_AUTONULL      = 0;
	localparam int GC_POWER_DOWN    = 1;
	localparam int GC_SELF_TEST     = 2;
	localparam int GC_FACTORY       = 3;
	localparam int GC_CLEAR_STATUS  = 4;
	localparam int GC_FLASH_TEST    = 5;
	localparam int GC_SAVE_REGS     = 6;
	localparam int GC_SOFT_RESET    = 7;
	localparam int GC_CLEAR_RECORDS = 8;
	localparam int GC_ERASE_BANDS   = 9;
	localparam int GC_BUF_PTR_ZERO  = 10;
	localparam int GC_RECORD_TOGGLE = 11;
	localparam int GC_SAVE_BANDS    = 12;
	localparam int GC_FETCH_RECORD  = 13;
	localparam int GC_LOAD_BANDS    = 14;
	localparam int GC_CLEAR_NULL    = 15;
	// Commands finished inside this block, not by the datapath
	localparam logic [15:0] GC_LOCAL_MASK = 16'h0012;

	// ------------------------------------------------------------
	// Alarm status layout and rate table
	// ------------------------------------------------------------
	localparam int XA_FLAGS_LSB = 4;
	localparam int XA_BAND_LSB  = 0;
	localparam logic [3:0] RATE_CODE_MIN = 4'h1;
	localparam logic [3:0] RATE_CODE_MAX = 4'h7;
	localparam logic [15:0] DECIM_RESET  = 16'h7421;

	// Power state of the sensor and controller
	typedef enum logic [0:0] {
		VSREG_AWAKE  = 1'b0,
		VSREG_ASLEEP = 1'b1
	} vsreg_power_t;

	// Register access from the serial deframer
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [6:0] addr;
		logic [7:0] wdata;
	} vsreg_req_t;

	// Rate answer: tenths of SPS and thousandths of Hz
	typedef struct packed {
		logic        valid;
		logic [21:0] rate_dsps;
		logic [16:0] bin_mhz;
	} vsreg_rate_t;

endpackage

/* src/vsreg_top.sv */
`timescale 1ns/10ps

module vsreg_top (
	// Clock and reset
	input  wire logic                 clk_i,
	input  wire logic                 rst_i,
	// Register access
	input  wire vsreg_pkg::vsreg_req_t req_i,
	output logic [15:0]               rdata_o,
	output logic                      rvalid_o,
	// Configuration from other registers
	input  wire logic                 latch_en_i,
	input  wire logic [15:0]          decim_ctrl_i,
	input  wire logic [1:0]           rate_sel_i,
	// Status conditions from the datapath
	input  wire logic                 sys_alarm_i,
	input  wire logic [2:0]           spec_alarm2_i,
	input  wire logic [2:0]           spec_alarm1_i,
	input  wire logic                 data_ready_i,
	input  wire logic                 flash_upd_fail_i,
	input  wire logic                 clk_count_err_i,
	input  wire logic                 supply_high_i,
	input  wire logic                 supply_low_i,
	input  wire logic                 escape_cmd_i,
	input  wire logic                 record_ok_i,
	// X-axis alarm results
	input  wire logic                 x_alarm_load_i,
	input  wire logic [11:0]          x_alarm_flags_i,
	input  wire logic [2:0]           x_alarm_band_i,
	// Command handshake with the datapath
	input  wire logic [15:0]          cmd_done_i,
	input  wire logic                 cmd_fail_i,
	output logic [15:0]               cmd_start_o,
	output logic [15:0]               cmd_busy_o,
	// Power control
	input  wire logic                 cs_n_i,
	input  wire logic                 timer_wake_i,
	output logic                      sleep_o,
	// Rate and bin width for the selected setting
	output vsreg_pkg::vsreg_rate_t    rate_o
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		// Register contents and command sequencing
		logic [15:0]             diag;
		logic [15:0]             cmd;
		logic [15:0]             issued;
		logic [15:0]             start;
		logic [15:0]             x_alarm;
		// Read answer
		logic [15:0]             rdata;
		logic                    rvalid;
		// Power and rate
		logic                    cs_prev;
		vsreg_pkg::vsreg_power_t power;
		vsreg_pkg::vsreg_rate_t  rate;
	} vsreg_state_t;

	vsreg_state_t state;
	vsreg_state_t next_state;

	// ------------------------------------------------------------
	// Usage notes
	// ------------------------------------------------------------

	// Writes are byte wide, reads word wide; only the command word is writable
	// Writes to read-only words are dropped without an answer
	// A written 1 stays pending in cmd_busy_o until its process ends
	// Each pending bit gives exactly one cmd_start_o pulse
	// Clear status and power-down end here; the rest wait for cmd_done_i
	// A done with no start behind it is ignored
	// cmd_fail_i is taken with the done of self test or flash test only
	// Software reset is only a start pulse; this bank keeps its contents
	// Event flags stay set until clear status, whatever the latch option
	// Level flags latch only while latch_en_i is high
	// Escape flag also drops after a good recording
	// Reads show state as of the edge before, one cycle behind the inputs
	// Sleep ends on either edge of cs_n_i or on a timer wake pulse

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------

	// Rate table, tenths of SPS and milli-Hz; each rate halves the last, except code 7 at 34385.
	// Code 0 and codes above 7 are not applicable and answer invalid
	function automatic vsreg_pkg::vsreg_rate_t rate_lookup(input logic [3:0] code);
		vsreg_pkg::vsreg_rate_t r;
		r = '0;
		r.valid = (code >= vsreg_pkg::RATE_CODE_MIN) && (code <= vsreg_pkg::RATE_CODE_MAX);
		unique case (code)
			4'h1: begin
				r.rate_dsps = 22'd2200000;
				r.bin_mhz   = 17'd53800;
			end
			4'h2: begin
				r.rate_dsps = 22'd1100000;
				r.bin_mhz   = 17'd26900;
			end
			4'h3: begin
				r.rate_dsps = 22'd550000;
				r.bin_mhz   = 17'd13400;
			end
			4'h4: begin
				r.rate_dsps = 22'd275000;
				r.bin_mhz   = 17'd6710;
			end
			4'h5: begin
				r.rate_dsps = 22'd137500;
				r.bin_mhz   = 17'd3350;
			end
			4'h6: begin
				r.rate_dsps = 22'd68750;
				r.bin_mhz   = 17'd1680;
			end
			4'h7: begin
				r.rate_dsps = 22'd34385;
				r.bin_mhz   = 17'd839;
			end
			default: begin
				r.rate_dsps = 22'h000000;
				r.bin_mhz   = 17'h00000;
			end
		endcase
		return r;
	endfunction

	// Byte write merge into one half of a 16-bit word
	function automatic logic [15:0] byte_lanes(input logic [6:0] addr, input logic [7:0] data);
		return addr[0] ? {data, 8'h00} : {8'h00, data};
	endfunction

	// Word match on bits 6..1; bit 0 only picks the byte lane of a write
	function automatic logic word_hit(input logic [6:0] addr, input logic [6:0] base);
		return addr[6:1] == base[6:1];
	endfunction

	// Sticky flag step; a set in the clearing cycle wins, so no event is lost
	function automatic logic flag_next(input logic held, input logic clear, input logic set);
		return (clear ? 1'b0 : held) | set;
	endfunction

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------

	// Decode, command sequencing, status flags and read data
	always_comb begin
		logic [15:0] cond;
		logic [15:0] events;
		logic [15:0] cmd_write;
		logic [15:0] finished;
		logic [3:0]  code;
		logic        clear_now;
		logic        wake;
		cond       = '0;
		events     = '0;
		cmd_write  = '0;
		finished   = '0;
		code       = 4'h0;
		clear_now  = 1'b0;
		wake       = 1'b0;
		next_state = state;

		// --------------------------------------------------------
		// Command register and sequencing
		// --------------------------------------------------------

		// Command writes land in either byte; bits only ever get set by the host
		if (req_i.wr && word_hit(req_i.addr, vsreg_pkg::GLOBAL_CMD_ADDR)) begin
			cmd_write = byte_lanes(req_i.addr, req_i.wdata);
		end

		// Completion: datapath done pulses, plus the two kept local.
		// A done with no start behind it is ignored, so a stray pulse is harmless
		finished = cmd_done_i & state.issued & ~vsreg_pkg::GC_LOCAL_MASK;
		// Clear status ends on its own start pulse: flags drop the cycle after
		finished[vsreg_pkg::GC_CLEAR_STATUS] = state.start[vsreg_pkg::GC_CLEAR_STATUS];
		clear_now = finished[vsreg_pkg::GC_CLEAR_STATUS];

		// Wake on any chip select edge or a timer capture while asleep
		wake = (state.power == vsreg_pkg::VSREG_ASLEEP)
			&& ((cs_n_i != state.cs_prev) || timer_wake_i);
		finished[vsreg_pkg::GC_POWER_DOWN] = state.issued[vsreg_pkg::GC_POWER_DOWN] && wake;
		// Select history resets high, its idle level, so reset gives no false wake
		next_state.cs_prev = cs_n_i;

		// Each pending bit starts once, one pulse, then waits for its finish.
		// Its own pulse masks a restart, as issued only rises the cycle after
		next_state.start  = state.cmd & ~(state.issued | state.start);
		next_state.issued = (state.issued | state.start) & ~finished;
		next_state.cmd    = (state.cmd & ~finished) | cmd_write;

		// --------------------------------------------------------
		// Power state
		// --------------------------------------------------------

		// Power state follows the power-down command
		unique case (state.power)
			vsreg_pkg::VSREG_AWAKE: begin
				if (state.start[vsreg_pkg::GC_POWER_DOWN]) begin
					next_state.power = vsreg_pkg::VSREG_ASLEEP;
				end
			end
			vsreg_pkg::VSREG_ASLEEP: begin
				if (wake) begin
					next_state.power = vsreg_pkg::VSREG_AWAKE;
				end
			end
		endcase

		// --------------------------------------------------------
		// Status flags
		// --------------------------------------------------------

		// Present conditions, level type
		cond[vsreg_pkg::DS_SYS_ALARM] = sys_alarm_i;
		cond[vsreg_pkg::DS_SPEC2_LSB +: 3] = spec_alarm2_i;
		cond[vsreg_pkg::DS_SPEC1_LSB +: 3] = spec_alarm1_i;
		cond[vsreg_pkg::DS_SUPPLY_HIGH] = supply_high_i;
		cond[vsreg_pkg::DS_SUPPLY_LOW]  = supply_low_i;

		// Events, set-type; sticky whatever the latch option,
		// since a one-cycle pulse would otherwise escape a slow host
		events[vsreg_pkg::DS_SELF_TEST] = finished[vsreg_pkg::GC_SELF_TEST] && cmd_fail_i;
		events[vsreg_pkg::DS_CHECKSUM] = finished[vsreg_pkg::GC_FLASH_TEST] && cmd_fail_i;
		events[vsreg_pkg::DS_FLASH_UPD] = flash_upd_fail_i;
		events[vsreg_pkg::DS_COMM_FAIL] = clk_count_err_i;
		events[vsreg_pkg::DS_ESCAPE] = escape_cmd_i;

		// Level flags: hold when latched, else track; clear loses to a new set
		for (int i = 0; i < 16; i++) begin
			if (!vsreg_pkg::DS_EVENT_MASK[i]) begin
				if (latch_en_i) begin
					next_state.diag[i] = flag_next(state.diag[i], clear_now, cond[i]);
				end else begin
					next_state.diag[i] = cond[i];
				end
			end else begin
				next_state.diag[i] = flag_next(state.diag[i], clear_now, events[i]);
			end
		end
		// Escape flag also clears after a good recording, but a new escape wins
		if (record_ok_i && !escape_cmd_i) begin
			next_state.diag[vsreg_pkg::DS_ESCAPE] = 1'b0;
		end
		// Ready indicator is live regardless of latching
		next_state.diag[vsreg_pkg::DS_DATA_READY] = data_ready_i;
		next_state.diag[15] = 1'b0;

		// --------------------------------------------------------
		// Alarm snapshot, rate and read port
		// --------------------------------------------------------

		// X-axis alarm results arrive as one snapshot per spectral record
		if (x_alarm_load_i) begin
			next_state.x_alarm[15:vsreg_pkg::XA_FLAGS_LSB] = x_alarm_flags_i;
			next_state.x_alarm[3] = 1'b0;
			next_state.x_alarm[vsreg_pkg::XA_BAND_LSB +: 3] = x_alarm_band_i;
		end

		// Selected nibble of the decimation control picks the rate.
		// A code of 0, or above 7, answers with valid low
		code = decim_ctrl_i[{rate_sel_i, 2'b00} +: 4];
		next_state.rate = rate_lookup(code);

		// Read port; command register is write-only and reads zero.
		// Data is the state before this edge, so a new flag shows one read later
		next_state.rvalid = req_i.rd;
		next_state.rdata  = 16'h0000;
		if (req_i.rd) begin
			if (word_hit(req_i.addr, vsreg_pkg::DIAG_STATUS_ADDR)) begin
				next_state.rdata = state.diag;
			end else if (word_hit(req_i.addr, vsreg_pkg::X_ALARM_STAT_ADDR)) begin
				next_state.rdata = state.x_alarm;
			end
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------

	// Software reset is a datapath command; it does not reset this bank
	// Reset loads constants only
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state.diag    <= vsreg_pkg::DIAG_STATUS_RESET;
			state.cmd     <= vsreg_pkg::GLOBAL_CMD_RESET;
			state.issued  <= 16'h0000;
			state.start   <= 16'h0000;
			state.x_alarm <= vsreg_pkg::X_ALARM_RESET;
			state.rdata   <= 16'h0000;
			state.rvalid  <= 1'b0;
			state.cs_prev <= 1'b1;
			state.power   <= vsreg_pkg::VSREG_AWAKE;
			state.rate    <= '0;
		end else begin
			state <= next_state;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------

	// All straight from the state flops
	// Sleep is the one power bit, so it too comes from a flop
	assign rdata_o     = state.rdata;
	assign rvalid_o    = state.rvalid;
	assign cmd_start_o = state.start;
	assign cmd_busy_o  = state.cmd;
	assign sleep_o     = (state.power == vsreg_pkg::VSREG_ASLEEP);
	assign rate_o      = state.rate;

endmodule

/* tb/vsreg_props.sv */
`timescale 1ns/10ps
module vsreg_props (
	// Clock and reset
	input wire logic                  clk_i,
	input wire logic                  rst_i,
	// Ports watched
	input wire vsreg_pkg::vsreg_req_t req_i,
	input wire logic [15:0]           cmd_done_i,
	input wire logic                  timer_wake_i,
	input wire logic [15:0]           cmd_start_o,
	input wire logic [15:0]           cmd_busy_o,
	input wire logic                  sleep_o
);
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// ------------------------------
	// Command life cycle
	// ------------------------------
	a_busy_on_write: assert property (
		req_i.wr && req_i.addr == 7'h3E && req_i.wdata[2] |=> cmd_busy_o[2])
		else $error("busy bit 2 not set by write");
	a_start_after_busy: assert property ($rose(cmd_busy_o[2]) |=> cmd_start_o[2])
		else $error("self test start missing");
	a_start_single: assert property (cmd_start_o[5] |=> !cmd_start_o[5])
		else $error("flash test start longer than one cycle");
	a_done_clears: assert property (cmd_busy_o[5] && cmd_done_i[5] |=> !cmd_busy_o[5])
		else $error("command bit 5 did not self clear");
	a_ptr_zero_start: assert property (
		req_i.wr && req_i.addr == 7'h3F && req_i.wdata[2] && !cmd_busy_o[10]
		|-> ##2 cmd_start_o[10])
		else $error("pointer zero start missing");
	a_clear_once: assert property (cmd_start_o[4] |=> !cmd_busy_o[4])
		else $error("clear status bit did not self clear");
	// Sleep is left only by a wake cause, never on its own
	a_sleep_entry: assert property (cmd_start_o[1] |=> sleep_o)
		else $error("power down did not sleep");
	a_sleep_wake: assert property (sleep_o && timer_wake_i |=> !sleep_o)
		else $error("timer did not wake");
	a_sleep_held: assert property (sleep_o |-> cmd_busy_o[1])
		else $error("asleep without pending power down");
	c_wake: cover property (sleep_o ##1 !sleep_o);
	c_self_test: cover property (cmd_start_o[2]);
	c_flash_done: cover property (cmd_done_i[5]);
endmodule

bind vsreg_top vsreg_props u_props (
	.clk_i        (clk_i),
	.rst_i        (rst_i),
	.req_i        (req_i),
	.cmd_done_i   (cmd_done_i),
	.timer_wake_i (timer_wake_i),
	.cmd_start_o  (cmd_start_o),
	.cmd_busy_o   (cmd_busy_o),
	.sleep_o      (sleep_o)
);

/* tb/vsreg_datapath_model.sv */
`timescale 1ns/10ps
module vsreg_datapath_model (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Command handshake
	input  wire logic [15:0] cmd_start_i,
	output logic [15:0]      cmd_done_o,
	output logic             cmd_fail_o,
	// Behaviour set by the bench
	input  wire logic        fail_i,
	input  wire logic [3:0]  dly_i
);
	logic [15:0] pend;
	logic [4:0]  cnt;
	// Bits 1 and 4 finish locally, so they never get a done
	always_ff @(posedge clk_i) begin
		cmd_done_o <= 16'h0000;
		if (rst_i) begin
			cnt <= 5'h00;
		end else if (cmd_start_i != 16'h0000) begin
			pend <= cmd_start_i & ~16'h0012;
			cnt  <= {1'b0, dly_i} + 5'h01;
		end else if (cnt != 5'h00) begin
			cnt <= cnt - 5'h01;
			if (cnt == 5'h01) begin
				cmd_done_o <= pend;
			end
		end
	end
	// Verdict of self test and flash sum, as commanded
	assign cmd_fail_o = fail_i;
endmodule

/* tb/status_and_global_command_regs_test.sv */
`timescale 1ns/10ps
module status_and_global_command_regs_test;
	logic                   clk_i = 1'b0;
	logic                   rst_i = 1'b1;
	vsreg_pkg::vsreg_req_t  req   = '0;
	logic                   latch = 1'b0, sys = 1'b0, dr = 1'b0, sh = 1'b0, sl = 1'b0;
	logic                   fupd = 1'b0, cce = 1'b0, esc = 1'b0, rok = 1'b0, xl = 1'b0;
	logic                   cs_n = 1'b1, tw = 1'b0, fail = 1'b0;
	logic [2:0]             sp2 = 3'h0, sp1 = 3'h0, xb = 3'h0;
	logic [11:0]            xf = 12'h000;
	logic [15:0]            decim = 16'h7421;
	logic [1:0]             rsel = 2'h0;
	logic [3:0]             dly = 4'h1;
	logic [15:0]            rdata, busy, start, done;
	logic                   rvalid, sleep, cfail;
	vsreg_pkg::vsreg_rate_t rate;
	int                     n_fail = 0, total_checks = 0;
	int                     nstart [16];
	int                     cl [12] = '{0, 3, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15};
	logic [21:0]            sps [7] = '{22'd2200000, 22'd1100000, 22'd550000, 22'd275000,
		22'd137500, 22'd68750, 22'd34385};
	logic [16:0]            bin [7] = '{17'd53800, 17'd26900, 17'd13400, 17'd6710,
		17'd3350, 17'd1680, 17'd839};
	// ------------------------------
	// Clock, design and far side
	// ------------------------------
	always #10 clk_i = ~clk_i;
	vsreg_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .rdata_o(rdata),
		.rvalid_o(rvalid), .latch_en_i(latch), .decim_ctrl_i(decim), .rate_sel_i(rsel),
		.sys_alarm_i(sys), .spec_alarm2_i(sp2), .spec_alarm1_i(sp1), .data_ready_i(dr),
		.flash_upd_fail_i(fupd), .clk_count_err_i(cce), .supply_high_i(sh),
		.supply_low_i(sl), .escape_cmd_i(esc), .record_ok_i(rok), .x_alarm_load_i(xl),
		.x_alarm_flags_i(xf), .x_alarm_band_i(xb), .cmd_done_i(done), .cmd_fail_i(cfail),
		.cmd_start_o(start), .cmd_busy_o(busy), .cs_n_i(cs_n), .timer_wake_i(tw),
		.sleep_o(sleep), .rate_o(rate));
	vsreg_datapath_model u_dp (.clk_i(clk_i), .rst_i(rst_i), .cmd_start_i(start),
		.cmd_done_o(done), .cmd_fail_o(cfail), .fail_i(fail), .dly_i(dly));
	// Start pulses counted, so a doubled pulse shows up
	always @(posedge clk_i) begin
		for (int i = 0; i < 16; i++) begin
			if (start[i] === 1'b1) begin
				nstart[i]++;
			end
		end
	end
	// ------------------------------
	// Access tasks
	// ------------------------------
	task automatic chk(input logic [21:0] got, input logic [21:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// Extra edge at the end keeps two writes from colliding in one step
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		req.wr    <= 1'b1;
		req.addr  <= a;
		req.wdata <= d;
		@(posedge clk_i);
		req.wr <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic rd(input logic [6:0] a, input logic [15:0] e);
		req.rd   <= 1'b1;
		req.addr <= a;
		@(posedge clk_i);
		req.rd <= 1'b0;
		#1;
		chk(rvalid, 1'b1);
		chk(rdata, e);
		@(posedge clk_i);
	endtask
	task automatic cmd(input int b);
		int n;
		n = nstart[b];
		wr(b > 7 ? 7'h3F : 7'h3E, 8'(1 << (b % 8)));
		for (int i = 0; i < 40; i++) begin
			#1;
			if (busy[b] === 1'b0) break;
			@(posedge clk_i);
		end
		chk(busy[b], 1'b0);
		chk(22'(nstart[b] - n), 22'd1);
		@(posedge clk_i);
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// Cut a hang short, far beyond the few hundred cycles needed
	initial begin
		#100000;
		n_fail++;
		end_of_test();
	end
	// ------------------------------
	// Test sequence
	// ------------------------------
	initial begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rd(7'h3C, 16'h0000);
		rd(7'h40, 16'h0000);
		wr(7'h3C, 8'hFF); // Read-only place ignores writes
		rd(7'h3C, 16'h0000);
		rd(7'h3E, 16'h0000);
		rd(7'h50, 16'h0000);
		$display("test reset done");
		{sys, sp2, sp1, dr, sh, sl} <= {1'b1, 3'h5, 3'h2, 1'b1, 1'b1, 1'b0};
		repeat (2) @(posedge clk_i);
		rd(7'h3C, 16'h6A82);
		{sys, sp2, sp1, dr, sh, sl} <= {1'b0, 3'h0, 3'h0, 1'b0, 1'b0, 1'b1};
		repeat (2) @(posedge clk_i);
		rd(7'h3C, 16'h0001);
		{latch, sys, sl} <= 3'b110;
		repeat (2) @(posedge clk_i);
		sys <= 1'b0;
		repeat (2) @(posedge clk_i);
		// Low supply was still set as latching began, so it holds as well
		rd(7'h3C, 16'h4001);
		cmd(4);
		rd(7'h3C, 16'h0000);
		$display("test level flags done");
		{fupd, cce, esc} <= 3'b111;
		@(posedge clk_i);
		{fupd, cce, esc} <= 3'b000;
		repeat (2) @(posedge clk_i);
		rd(7'h3C, 16'h001C);
		rok <= 1'b1;
		@(posedge clk_i);
		rok <= 1'b0;
		repeat (2) @(posedge clk_i);
		rd(7'h3C, 16'h000C);
		cmd(4);
		$display("test event flags done");
		fail <= 1'b1;
		dly  <= 4'h6;
		cmd(2);
		rd(7'h3C, 16'h0020);
		cmd(5);
		rd(7'h3C, 16'h0060);
		fail <= 1'b0;
		cmd(4);
		for (int i = 0; i < 12; i++) begin
			dly <= 4'(i * 3);
			cmd(cl[i]);
		end
		rd(7'h3C, 16'h0000);
		$display("test commands done");
		wr(7'h3E, 8'h02);
		@(posedge clk_i);
		#1;
		chk(sleep, 1'b1);
		@(posedge clk_i);
		cs_n <= 1'b0;
		repeat (2) @(posedge clk_i);
		#1;
		chk({busy[1], sleep}, 2'b00);
		@(posedge clk_i);
		cs_n <= 1'b1;
		repeat (2) @(posedge clk_i);
		wr(7'h3E, 8'h02);
		@(posedge clk_i);
		#1;
		chk(sleep, 1'b1);
		@(posedge clk_i);
		tw <= 1'b1;
		@(posedge clk_i);
		tw <= 1'b0;
		@(posedge clk_i);
		#1;
		chk({busy[1], sleep}, 2'b00);
		@(posedge clk_i);
		$display("test power down done");
		{xl, xf, xb} <= {1'b1, 12'hABC, 3'h5};
		@(posedge clk_i);
		xl <= 1'b0;
		repeat (2) @(posedge clk_i);
		rd(7'h40, 16'hABC5);
		// Other nibbles hold code 0, so a wrong nibble pick shows
		for (int c = 1; c < 8; c++) begin
			decim <= 16'(c) << (4 * (c % 4));
			rsel  <= 2'(c % 4);
			repeat (2) @(posedge clk_i);
			#1;
			chk(rate.valid, 1'b1);
			chk(rate.rate_dsps, sps[c-1]);
			chk(rate.bin_mhz, bin[c-1]);
			@(posedge clk_i);
		end
		// Nibble 0 now holds code 0, which has no rate
		rsel <= 2'h0;
		repeat (2) @(posedge clk_i);
		#1;
		chk(rate.valid, 1'b0);
		@(posedge clk_i);
		$display("test alarm and rate done");
		end_of_test();
	end
endmodule
